// ==== hdl/rtcca_top.v ====
// capture, pin configuration and alarm registers of the real-time clock, AHB-Lite slave
//
// Summary of operation
// RQ1: writing 0xe7 to pin config shorts the two crystal pins internally.
// RQ2: writing 0x67 to pin config removes the short, pins separate again.
// RQ3: four capture bytes form a 32-bit value to read or preset the timer.
// RQ4: capture and timer exchange data only on load or snapshot request.
// RQ5: capture bytes sit at internal addresses 0x00 to 0x03, byte 0 lowest.
// RQ6: four alarm bytes hold the 32-bit alarm match value.
// RQ7: alarm bytes sit at internal addresses 0x08 to 0x0b, byte 0 at 0x08.
// RQ8: alarm byte 0 bit 0 is the alarm value's least significant bit.
// RQ9: software should disable the alarm before changing alarm bytes.
// RQ10: writing 1 to load request copies capture into timer; hardware clears it.
// RQ11: writing 1 to snapshot request copies timer into capture; hardware clears it.
// RQ12: oscillator mode select 0 is self-oscillate, 1 is crystal mode.
// RQ13: with alarm enabled, timer equal to alarm value raises an alarm flag.
// RQ14: pin config is write-only; other codes leave the pins unchanged.
//
// Implementation choice: the AHB-Lite register port.
`default_nettype none
`include "rtcca_map.vh"
module rtcca_top (
   input  wire        core_clk,
   input  wire        reset,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   input  wire [31:0] timer_value,
   output reg         timer_load,
   output wire [31:0] timer_load_value,
   output reg         crystal_pins_shorted,
   output wire        osc_mode_select,
   output wire        alarm_enable_bit,
   output reg         alarm_event,
   output wire        irq
);
   localparam ST_IDLE = 2'd0;
   localparam ST_LOAD = 2'd1;
   localparam ST_SNAP = 2'd2;

   reg        ph_write;
   reg [3:0]  ph_idx;
   reg        ph_valid;
   reg        load_request;
   reg        snapshot_request;
   reg        alarm_en;
   reg        osc_mode;
   reg [`RTCCA_INT_W-1:0] int_status;
   reg [`RTCCA_INT_W-1:0] int_mask;
   reg [1:0]  state;
   reg [1:0]  xfer_cnt;
   reg        match_d;
   wire [31:0] capture_value;
   wire [31:0] alarm_value;
   wire        wr;
   wire        snap_hw;
   wire        match;
   wire [`RTCCA_INT_W-1:0] int_set;
   wire        xfer_end;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign wr        = ph_valid & ph_write;
   assign osc_mode_select  = osc_mode; // [RQ12]
   assign alarm_enable_bit = alarm_en;
   assign timer_load_value = capture_value; // [RQ10]
   assign xfer_end  = (xfer_cnt == (`RTCCA_XFER_CYCLES - 1));
   assign snap_hw   = (state == ST_SNAP) & xfer_end; // [RQ4] [RQ11]
   // alarm byte 0 bit 0 is bit 0 of the compared value
   assign match     = alarm_en & (timer_value == alarm_value); // [RQ8] [RQ13]

   // address phase capture; word offsets, index is byte address over four
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_idx   <= 4'h0;
      end else if (hready) begin
         ph_valid <= hsel & htrans[1];
         ph_write <= hwrite;
         ph_idx   <= haddr[5:2];
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_bytes
         rtcca_byte_reg #(.RESET_VALUE(`RTCCA_BYTE_RESET)) u_capture (
            .core_clk (core_clk),
            .reset    (reset),
            .bus_we   (wr & (ph_idx == `RTCCA_IDX_TIMER_CAPTURE_BYTE0 + g)), // [RQ3] [RQ5]
            .bus_data (hwdata[7:0]),
            .hw_we    (snap_hw),
            .hw_data  (timer_value[8*g+7:8*g]),
            .value    (capture_value[8*g+7:8*g])
         );
         rtcca_byte_reg #(.RESET_VALUE(`RTCCA_BYTE_RESET)) u_alarm (
            .core_clk (core_clk),
            .reset    (reset),
            .bus_we   (wr & (ph_idx == `RTCCA_IDX_ALARM_VALUE_BYTE0 + g)), // [RQ6] [RQ7]
            .bus_data (hwdata[7:0]),
            .hw_we    (1'b0),
            .hw_data  (8'h00),
            .value    (alarm_value[8*g+7:8*g])
         );
      end
   endgenerate

   // control bits, pin configuration and transfer sequencing
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         load_request         <= 1'b0;
         snapshot_request     <= 1'b0;
         alarm_en             <= 1'b0;
         osc_mode             <= 1'b0;
         crystal_pins_shorted <= 1'b0;
         state                <= ST_IDLE;
         xfer_cnt             <= 2'd0;
         timer_load           <= 1'b0;
      end else begin
         timer_load <= 1'b0;
         if (wr && ph_idx == `RTCCA_IDX_CONTROL) begin
            alarm_en <= hwdata[`RTCCA_CTL_ALMEN];
            if (hwdata[`RTCCA_CTL_LOAD])
               load_request <= 1'b1; // [RQ10]
            if (hwdata[`RTCCA_CTL_SNAP])
               snapshot_request <= 1'b1; // [RQ11]
         end
         if (wr && ph_idx == `RTCCA_IDX_OSCCTL)
            osc_mode <= hwdata[`RTCCA_OSC_MODE];
         if (wr && ph_idx == `RTCCA_IDX_PINCFG) begin
            if (hwdata[7:0] == `RTCCA_PIN_SHORT)
               crystal_pins_shorted <= 1'b1; // [RQ1]
            else if (hwdata[7:0] == `RTCCA_PIN_NORMAL)
               crystal_pins_shorted <= 1'b0; // [RQ2] [RQ14]
         end
         case (state)
            ST_IDLE: begin
               xfer_cnt <= 2'd0;
               // load wins when both are requested; snapshot follows
               if (load_request)
                  state <= ST_LOAD;
               else if (snapshot_request)
                  state <= ST_SNAP;
            end
            ST_LOAD: begin
               xfer_cnt <= xfer_cnt + 2'd1;
               if (xfer_end) begin
                  timer_load   <= 1'b1; // [RQ4] [RQ10]
                  load_request <= 1'b0;
                  state        <= ST_IDLE;
               end
            end
            ST_SNAP: begin
               xfer_cnt <= xfer_cnt + 2'd1;
               if (xfer_end) begin
                  snapshot_request <= 1'b0; // [RQ11]
                  state            <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // alarm flag on the rising edge of a match, sticky interrupt status
   assign int_set = {snap_hw, (state == ST_LOAD) & xfer_end, match & ~match_d};

   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         match_d     <= 1'b0;
         alarm_event <= 1'b0;
         int_status  <= {`RTCCA_INT_W{1'b0}};
         int_mask    <= {`RTCCA_INT_W{1'b0}};
      end else begin
         match_d     <= match;
         alarm_event <= match & ~match_d; // [RQ13]
         if (wr && ph_idx == `RTCCA_IDX_INTMASK)
            int_mask <= hwdata[`RTCCA_INT_W-1:0];
         // set wins over a write-one clear in the same cycle
         if (wr && ph_idx == `RTCCA_IDX_INTSTAT)
            int_status <= (int_status & ~hwdata[`RTCCA_INT_W-1:0]) | int_set;
         else
            int_status <= int_status | int_set;
      end
   end

   assign irq = |(int_status & int_mask);

   // read data registered at the address phase; pin config reads zero
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr[5:2])
            `RTCCA_IDX_TIMER_CAPTURE_BYTE0: hrdata <= {24'h00_0000, capture_value[7:0]};
            `RTCCA_IDX_TIMER_CAPTURE_BYTE1: hrdata <= {24'h00_0000, capture_value[15:8]};
            `RTCCA_IDX_TIMER_CAPTURE_BYTE2: hrdata <= {24'h00_0000, capture_value[23:16]};
            `RTCCA_IDX_TIMER_CAPTURE_BYTE3: hrdata <= {24'h00_0000, capture_value[31:24]};
            `RTCCA_IDX_CONTROL:  hrdata <= {29'h0000_0000, alarm_en, load_request,
                                            snapshot_request};
            `RTCCA_IDX_OSCCTL:   hrdata <= {25'h000_0000, osc_mode, 6'h00};
            `RTCCA_IDX_ALARM_VALUE_BYTE0:   hrdata <= {24'h00_0000, alarm_value[7:0]};
            `RTCCA_IDX_ALARM_VALUE_BYTE1:   hrdata <= {24'h00_0000, alarm_value[15:8]};
            `RTCCA_IDX_ALARM_VALUE_BYTE2:   hrdata <= {24'h00_0000, alarm_value[23:16]};
            `RTCCA_IDX_ALARM_VALUE_BYTE3:   hrdata <= {24'h00_0000, alarm_value[31:24]};
            `RTCCA_IDX_INTSTAT:  hrdata <= {29'h0000_0000, int_status};
            `RTCCA_IDX_INTMASK:  hrdata <= {29'h0000_0000, int_mask};
            default:             hrdata <= 32'h0000_0000; // [RQ14]
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== shared/rtcca_map.vh ====
// register offsets, field positions and reset values of the capture and alarm block
`ifndef RTCCA_MAP_VH
`define RTCCA_MAP_VH
// internal byte offsets, kept as indices; byte address is four times the index
`define RTCCA_IDX_TIMER_CAPTURE_BYTE0   4'h0
`define RTCCA_IDX_TIMER_CAPTURE_BYTE1   4'h1
`define RTCCA_IDX_TIMER_CAPTURE_BYTE2   4'h2
`define RTCCA_IDX_TIMER_CAPTURE_BYTE3   4'h3
`define RTCCA_IDX_CONTROL    4'h4
`define RTCCA_IDX_OSCCTL     4'h5
`define RTCCA_IDX_PINCFG     4'h7
`define RTCCA_IDX_ALARM_VALUE_BYTE0     4'h8
`define RTCCA_IDX_ALARM_VALUE_BYTE1     4'h9
`define RTCCA_IDX_ALARM_VALUE_BYTE2     4'ha
`define RTCCA_IDX_ALARM_VALUE_BYTE3     4'hb
`define RTCCA_IDX_INTSTAT    4'hc
`define RTCCA_IDX_INTMASK    4'hd
// control register fields
`define RTCCA_CTL_SNAP       0
`define RTCCA_CTL_LOAD       1
`define RTCCA_CTL_ALMEN      2
// oscillator control field
`define RTCCA_OSC_MODE       6
// interrupt status fields
`define RTCCA_INT_ALARM      0
`define RTCCA_INT_LOADDONE   1
`define RTCCA_INT_SNAPDONE   2
`define RTCCA_INT_W          3
// pin configuration codes
`define RTCCA_PIN_SHORT      8'he7
`define RTCCA_PIN_NORMAL     8'h67
`define RTCCA_PIN_RESET      8'h67
`define RTCCA_BYTE_RESET     8'h00
// transfer takes this many clock cycles
`define RTCCA_XFER_CYCLES    2
`endif

// ==== hdl/rtcca_byte_reg.v ====
// one byte-wide register with bus write and hardware load
`default_nettype none
module rtcca_byte_reg #(
   parameter [7:0] RESET_VALUE = 8'h00
) (
   input  wire       core_clk,
   input  wire       reset,
   input  wire       bus_we,
   input  wire [7:0] bus_data,
   input  wire       hw_we,
   input  wire [7:0] hw_data,
   output reg  [7:0] value
);
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         value <= RESET_VALUE;
      end else if (hw_we) begin
         value <= hw_data;
      end else if (bus_we) begin
         value <= bus_data;
      end
   end
endmodule
`default_nettype wire

// ==== bench/rtcca_chk.sv ====
// concurrent checks on the capture, pin and alarm register block
`default_nettype none
module rtcca_chk (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic [31:0] timer_value,
   input wire logic        timer_load,
   input wire logic [31:0] timer_load_value,
   input wire logic        crystal_pins_shorted,
   input wire logic        osc_mode_select,
   input wire logic        alarm_enable_bit,
   input wire logic        alarm_event
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       ph_w;
   logic       ph_r;
   logic [3:0] ph_idx;
   // data phase tracker, so checks line up with hwdata and hrdata
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ph_w <= 1'b0;
         ph_r <= 1'b0;
         ph_idx <= 4'h0;
      end else begin
         ph_w <= hsel && hready && htrans[1] && hwrite;
         ph_r <= hsel && hready && htrans[1] && !hwrite;
         ph_idx <= haddr[5:2];
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence pin_wr(logic [7:0] code);
      ph_w && ph_idx == 4'h7 && hwdata[7:0] == code;
   endsequence
   sequence pin_other;
      ph_w && ph_idx == 4'h7 && hwdata[7:0] != 8'he7 && hwdata[7:0] != 8'h67;
   endsequence
   sequence ctl_wr(int b);
      ph_w && ph_idx == 4'h4 && hwdata[b];
   endsequence
   sequence no_ctl;
      !(ph_w && ph_idx == 4'h4);
   endsequence
   pin_short_a: assert property (pin_wr(8'he7) |=> crystal_pins_shorted)
      else $error("pin short missed");
   pin_normal_a: assert property (pin_wr(8'h67) |=> !crystal_pins_shorted)
      else $error("pin short not removed");
   pin_keep_a: assert property (pin_other |=> $stable(crystal_pins_shorted))
      else $error("pin state changed by other code");
   pin_wo_a: assert property (ph_r && ph_idx == 4'h7 |-> hrdata == 32'h0)
      else $error("pin config readable");
   cap_wr_a: assert property (ph_w && ph_idx == 4'h0 |=>
      timer_load_value[7:0] == $past(hwdata[7:0])) else $error("capture byte 0 wrong");
   load_req_a: assert property (ctl_wr(1) |-> ##[1:6] timer_load)
      else $error("load not done");
   load_only_a: assert property (no_ctl [*8] |=> !timer_load)
      else $error("load without request");
   snap_req_a: assert property (ctl_wr(0) |-> ##[1:6] timer_load_value == timer_value)
      else $error("snapshot not taken");
   osc_mode_a: assert property (ph_w && ph_idx == 4'h5 |=>
      osc_mode_select == $past(hwdata[6])) else $error("oscillator mode wrong");
   alarm_ev_a: assert property (alarm_event |-> alarm_enable_bit ##1 !alarm_event)
      else $error("alarm event wrong");
endmodule
bind rtcca_top rtcca_chk i_chk (.core_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hrdata, .timer_value, .timer_load, .timer_load_value, .crystal_pins_shorted,
   .osc_mode_select, .alarm_enable_bit, .alarm_event);
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench of the capture, pin and alarm register block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [3:0] i; logic [7:0] w; logic [31:0] e;} rtcca_row_t;
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] timer_value = 32'h0;
   logic [31:0] hrdata, timer_load_value, rd;
   logic        hready, hreadyout, hresp, timer_load, crystal_pins_shorted;
   logic        osc_mode_select, alarm_enable_bit, alarm_event, irq;
   int          n_errors = 0;
   int          checked = 0;
   int          n;
   // capture, alarm, write-only pin config, unmapped place
   rtcca_row_t  rows [10] = '{'{4'h0, 8'h11, 32'h11}, '{4'h1, 8'h22, 32'h22},
      '{4'h2, 8'h33, 32'h33}, '{4'h3, 8'h44, 32'h44}, '{4'h8, 8'ha1, 32'ha1},
      '{4'h9, 8'ha2, 32'ha2}, '{4'ha, 8'ha3, 32'ha3}, '{4'hb, 8'ha4, 32'ha4},
      '{4'h7, 8'he7, 32'h0}, '{4'hf, 8'h5a, 32'h0}};
   assign hready = hreadyout;
   always #10 core_clk = ~core_clk;
   rtcca_top i_dut (.core_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .timer_value, .timer_load, .timer_load_value,
      .crystal_pins_shorted, .osc_mode_select, .alarm_enable_bit, .alarm_event, .irq);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [3:0] i, input logic [7:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {26'h0, i, 2'b00};
      @(posedge core_clk);
      while (hready !== 1'b1) @(posedge core_clk);
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      @(posedge core_clk);
      while (hready !== 1'b1) @(posedge core_clk);
      rd = hrdata;
      // let the edge's register updates land before outputs are looked at
      #1;
   endtask
   task automatic summarize;
      $display("mismatches %0d, comparisons %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      check(crystal_pins_shorted, 32'h0);
      check(hresp, 32'h0);
      check(hreadyout, 32'h1);
      xfer(1'b0, 4'h0, 8'h00);
      check(rd, 32'h0);
      xfer(1'b0, 4'hb, 8'h00);
      check(rd, 32'h0);
      // alarm stays disabled while its bytes change
      foreach (rows[k]) begin
         xfer(1'b1, rows[k].i, rows[k].w);
         xfer(1'b0, rows[k].i, 8'h00);
         check(rd, rows[k].e);
      end
      check(crystal_pins_shorted, 32'h1);
      check(timer_load_value, 32'h44332211);
      xfer(1'b1, 4'h7, 8'h12);
      check(crystal_pins_shorted, 32'h1);
      xfer(1'b1, 4'h7, 8'h67);
      check(crystal_pins_shorted, 32'h0);
      xfer(1'b1, 4'h5, 8'h40);
      check(osc_mode_select, 32'h1);
      xfer(1'b1, 4'h5, 8'h00);
      check(osc_mode_select, 32'h0);
      xfer(1'b1, 4'h4, 8'h02);
      n = 0;
      // look just after the edge, never in the time step that launches the pulse
      while (timer_load !== 1'b1 && n < 20) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check(timer_load, 32'h1);
      repeat (3) @(posedge core_clk);
      xfer(1'b0, 4'h4, 8'h00);
      check(rd[1], 32'h0);
      timer_value <= 32'hdeadbeef;
      xfer(1'b1, 4'h4, 8'h01);
      repeat (6) @(posedge core_clk);
      for (int k = 0; k < 4; k++) begin
         xfer(1'b0, k[3:0], 8'h00);
         check(rd, (32'hdeadbeef >> (8 * k)) & 32'hff);
      end
      xfer(1'b0, 4'h4, 8'h00);
      check(rd[0], 32'h0);
      xfer(1'b1, 4'hd, 8'h01);
      timer_value <= 32'ha4a3a2a1;
      xfer(1'b1, 4'h4, 8'h04);
      n = 0;
      while (alarm_event !== 1'b1 && n < 20) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check(alarm_event, 32'h1);
      #1;
      check(irq, 32'h1);
      xfer(1'b1, 4'hd, 8'h00);
      check(irq, 32'h0);
      xfer(1'b1, 4'hd, 8'h01);
      check(irq, 32'h1);
      xfer(1'b1, 4'hc, 8'h07);
      check(irq, 32'h0);
      // mid-run reset must drop the short and clear the capture bytes
      xfer(1'b1, 4'h7, 8'he7);
      check(crystal_pins_shorted, 32'h1);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      #1;
      check(crystal_pins_shorted, 32'h0);
      check(timer_load_value, 32'h0);
      check(alarm_enable_bit, 32'h0);
      xfer(1'b0, 4'h8, 8'h00);
      check(rd, 32'h0);
      summarize();
   end
   initial begin
      #100000;
      n_errors++;
      summarize();
   end
endmodule
`default_nettype wire
